// ### jtl_regs.svh
// offsets, reset values and limits for the transport config block
`ifndef JTL_REGS_SVH
`define JTL_REGS_SVH
`define JTL_PLL_BAND_ADDR   12'h56e
`define JTL_CTRL_OFS        12'h000
`define JTL_LINK_OFS        12'h004
`define JTL_RATE_OFS        12'h008
`define JTL_FS_OFS          12'h00c
`define JTL_STAT_OFS        12'h010
`define JTL_PLL_OFS         12'h014
`define JTL_SLR_MIN_KBPS    24'd1687500
`define JTL_SLR_B1_KBPS     24'd3375000
`define JTL_SLR_B2_KBPS     24'd6750000
`define JTL_SLR_B3_KBPS     24'd13500000
`define JTL_SLR_MAX_KBPS    24'd16000000
`define JTL_LCM_MAX         12'd64
`define JTL_PLL_BAND0       8'h50
`define JTL_PLL_BAND1       8'h10
`define JTL_PLL_BAND2       8'h00
`define JTL_PLL_BAND3       8'h30
`define JTL_K_MAX           6'd32
`define JTL_RATE_UNIT       8'd20
`endif

// ### jtl_pkg.sv
// shared types for the transport config block
package jtl_pkg;
	typedef enum logic [1:0] {JTL_IDLE, JTL_WR, JTL_WAIT} jtl_cmd_state_t;
	typedef enum logic [1:0] {JTL_RUN_OFF, JTL_RUN_ON} jtl_run_t;
	typedef logic [7:0] jtl_byte_t;
endpackage

// ### jtl_link_if.sv
// link between the converter end and the receiving logic end
`timescale 1ns/1ps
`default_nettype none
interface jtl_link_if;
	logic       cfg_we;
	logic [11:0] cfg_addr;
	logic [7:0]  cfg_wdata;
	logic        cfg_ack;
	logic        link_up;
	logic [31:0] lane_data;
	logic        lane_valid;
	modport dev (input cfg_we, cfg_addr, cfg_wdata, output cfg_ack, link_up, lane_data, lane_valid);
	modport rcv (output cfg_we, cfg_addr, cfg_wdata, input cfg_ack, link_up, lane_data, lane_valid);
endinterface
`default_nettype wire

// ### jtl_cfg_check.sv
// legality check of one transport configuration
//
// Design decision made here: the unrounded check of the lane rate against fout.
`timescale 1ns/1ps
`default_nettype none
`include "jtl_regs.svh"
module jtl_cfg_check
	import jtl_pkg::*;
(
	input  wire logic [2:0]  lanes_i,
	input  wire logic [3:0]  conv_i,
	input  wire logic [4:0]  octets_i,
	input  wire logic [3:0]  samples_i,
	input  wire logic [5:0]  frames_i,
	input  wire logic [1:0]  ctrl_bits_i,
	input  wire logic [3:0]  resolution_i,
	input  wire logic        hd_i,
	input  wire logic [3:0]  dcm_i,
	input  wire logic [23:0] slr_kbps_i,
	input  wire logic [23:0] fadc_ksps_i,
	output logic             legal_o,
	output logic [7:0]       band_o
);
	logic [1:0]  band;
	logic [7:0]  ratio2;
	logic        row_ok;
	logic        k_ok;
	logic        rate_ok;
	logic        dcm_ok;
	logic [11:0] lcm;
	logic [11:0] q;
	logic [23:0] fout;
	logic [31:0] prod;
	logic [31:0] slr_x2dcm;
	logic [31:0] fadc_xr;
	always_comb begin
		// lane rate band
		if (slr_kbps_i < `JTL_SLR_B1_KBPS) band = 2'd0;
		else if (slr_kbps_i < `JTL_SLR_B2_KBPS) band = 2'd1;
		else if (slr_kbps_i <= `JTL_SLR_B3_KBPS) band = 2'd2;
		else band = 2'd3;
		case (band)
			2'd0: band_o = `JTL_PLL_BAND0;
			2'd1: band_o = `JTL_PLL_BAND1;
			2'd2: band_o = `JTL_PLL_BAND2;
			default: band_o = `JTL_PLL_BAND3;
		endcase
	end
	always_comb begin
		// table rows: lane rate in units of fout/2
		row_ok = 1'b0;
		ratio2 = 8'd0;
		if (conv_i == 4'd1 && lanes_i == 3'd1 && (octets_i == 5'd1 || octets_i == 5'd2)
			&& samples_i == octets_i[3:0]) begin
			row_ok = 1'b1;
			ratio2 = 8'd20;
		end else if (conv_i == 4'd1 && lanes_i == 3'd2 && samples_i == {octets_i[2:0], 1'b0}
			&& (octets_i == 5'd1 || octets_i == 5'd2 || octets_i == 5'd4)) begin
			row_ok = 1'b1;
			ratio2 = 8'd10;
		end else if (conv_i == 4'd1 && lanes_i == 3'd4 && (octets_i == 5'd1 || octets_i == 5'd2)
			&& samples_i == {octets_i[1:0], 2'b00}) begin
			row_ok = 1'b1;
			ratio2 = 8'd5;
		end else if (conv_i == 4'd2 && lanes_i == 3'd1 && octets_i == 5'd2 && samples_i == 4'd1) begin
			row_ok = 1'b1;
			ratio2 = 8'd40;
		end else if (conv_i == 4'd2 && lanes_i == 3'd2 && (octets_i == 5'd1 || octets_i == 5'd2)
			&& samples_i == octets_i[3:0]) begin
			row_ok = 1'b1;
			ratio2 = 8'd20;
		end else if (conv_i == 4'd2 && lanes_i == 3'd4 && samples_i == {octets_i[2:0], 1'b0}
			&& (octets_i == 5'd1 || octets_i == 5'd2 || octets_i == 5'd4)) begin
			row_ok = 1'b1;
			ratio2 = 8'd10;
		end
	end
	always_comb begin
		// decimation per band, from the listed columns
		dcm_ok = 1'b0;
		case (ratio2)
			8'd40: dcm_ok = (band == 2'd0 && (dcm_i == 4'd2 || dcm_i == 4'd4 || dcm_i == 4'd5
				|| dcm_i == 4'd6)) || (band == 2'd1 && dcm_i >= 4'd1 && dcm_i <= 4'd3)
				|| (band == 2'd2 && dcm_i == 4'd1);
			8'd20: dcm_ok = (band == 2'd0 && dcm_i >= 4'd1 && dcm_i <= 4'd3)
				|| (band == 2'd1 && dcm_i == 4'd1);
			8'd10: dcm_ok = band == 2'd0 && dcm_i == 4'd1;
			default: dcm_ok = 1'b0;
		endcase
	end
	always_comb begin
		// k range per octet count, steps of four
		k_ok = frames_i[1:0] == 2'b00 && frames_i <= `JTL_K_MAX;
		case (octets_i)
			5'd1: k_ok = k_ok && frames_i >= 6'd20;
			5'd2: k_ok = k_ok && frames_i >= 6'd12;
			5'd4: k_ok = k_ok && frames_i >= 6'd8;
			5'd8, 5'd16: k_ok = k_ok && frames_i >= 6'd4;
			default: k_ok = 1'b0;
		endcase
	end
	always_comb begin
		// fout from decimation; lcm(20*dcm*fout/slr, dcm)
		fout = (dcm_i == 4'd0) ? 24'd0 : fadc_ksps_i / {20'd0, dcm_i};
		q = (ratio2 == 8'd0) ? 12'd0 : 12'(({4'd0, dcm_i} * 8'd40) / ratio2);
		lcm = (q % {8'd0, dcm_i} == 12'd0) ? q : q * {8'd0, dcm_i};
		prod = {8'd0, fadc_ksps_i} * 32'd40;
		// lane rate must be the row's multiple of fout, compared unrounded
		slr_x2dcm = {7'd0, slr_kbps_i, 1'b0} * {28'd0, dcm_i};
		fadc_xr = {8'd0, fadc_ksps_i} * {24'd0, ratio2};
		rate_ok = slr_kbps_i >= `JTL_SLR_MIN_KBPS && slr_kbps_i <= `JTL_SLR_MAX_KBPS
			&& {8'd0, slr_kbps_i} <= prod && lcm <= `JTL_LCM_MAX && lcm != 12'd0
			&& fout != 24'd0 && slr_x2dcm == fadc_xr;
	end
	// 8-bit word: resolution 7..8, cs 0..1, no high density
	assign legal_o = row_ok && dcm_ok && k_ok && rate_ok && ctrl_bits_i <= 2'd1
		&& (resolution_i == 4'd7 || resolution_i == 4'd8) && !hd_i;
endmodule
`default_nettype wire

// ### jtl_dev.sv
// converter end: checks config, holds pll band register, frames samples
`timescale 1ns/1ps
`default_nettype none
`include "jtl_regs.svh"
module jtl_dev
	import jtl_pkg::*;
(
	input  wire logic        CLK_I,
	input  wire logic        NRST_I,
	jtl_link_if.dev          LINK,
	input  wire logic [2:0]  LANES_I,
	input  wire logic [3:0]  CONV_I,
	input  wire logic [4:0]  OCTETS_I,
	input  wire logic [3:0]  SAMPLES_I,
	input  wire logic [5:0]  FRAMES_I,
	input  wire logic [1:0]  CTRL_BITS_I,
	input  wire logic [3:0]  RESOLUTION_I,
	input  wire logic        HD_I,
	input  wire logic        DDC_I,
	input  wire logic [3:0]  DCM_I,
	input  wire logic [23:0] SLR_KBPS_I,
	input  wire logic [23:0] FADC_KSPS_I,
	input  wire logic [7:0]  SAMPLE_I,
	input  wire logic        SAMPLE_CTRL_I,
	output logic             ILLEGAL_O,
	output logic             BAND_MISMATCH_O,
	output logic [7:0]       PLL_BAND_O
);
	logic        legal;
	logic [7:0]  band_need;
	logic [3:0]  conv_eff;
	logic [7:0]  pll_band_q;
	logic        run_q;
	logic [31:0] word_q;
	logic [1:0]  slot_q;
	logic [3:0]  dcm_cnt_q;
	logic        out_en;
	logic [7:0]  octet;
	logic        lane_valid_q;
	// ddc mode counts i and q as two converters each
	assign conv_eff = DDC_I ? {CONV_I[2:0], 1'b0} : CONV_I;
	jtl_cfg_check jtl_cfg_check_i (
		.lanes_i      (LANES_I),
		.conv_i       (conv_eff),
		.octets_i     (OCTETS_I),
		.samples_i    (SAMPLES_I),
		.frames_i     (FRAMES_I),
		.ctrl_bits_i  (CTRL_BITS_I),
		.resolution_i (RESOLUTION_I),
		.hd_i         (HD_I),
		.dcm_i        (DCM_I),
		.slr_kbps_i   (SLR_KBPS_I),
		.fadc_ksps_i  (FADC_KSPS_I),
		.legal_o      (legal),
		.band_o       (band_need)
	);
	always_ff @(posedge CLK_I) begin
		// band register written by the far end
		if (!NRST_I) begin
			pll_band_q <= `JTL_PLL_BAND2;
		end else if (LINK.cfg_we && LINK.cfg_addr == `JTL_PLL_BAND_ADDR) begin
			pll_band_q <= LINK.cfg_wdata;
		end
	end
	assign LINK.cfg_ack = LINK.cfg_we;
	always_ff @(posedge CLK_I) begin
		// transmitter held idle while config or band is wrong
		if (!NRST_I) begin
			run_q <= 1'b0;
		end else begin
			run_q <= legal && pll_band_q == band_need;
		end
	end
	always_ff @(posedge CLK_I) begin
		// one output sample every dcm clocks
		if (!NRST_I || !run_q) begin
			dcm_cnt_q <= 4'h0;
		end else if (dcm_cnt_q + 4'h1 >= DCM_I) begin
			dcm_cnt_q <= 4'h0;
		end else begin
			dcm_cnt_q <= dcm_cnt_q + 4'h1;
		end
	end
	assign out_en = run_q && dcm_cnt_q == 4'h0;
	// n-bit sample, with one control bit in the lsb when cs is set
	assign octet = (CTRL_BITS_I != 2'd0) ? {SAMPLE_I[7:1], SAMPLE_CTRL_I} : SAMPLE_I;
	always_ff @(posedge CLK_I) begin
		// packs samples into a four octet word across lanes
		if (!NRST_I || !run_q) begin
			word_q <= 32'h0000_0000;
			slot_q <= 2'd0;
		end else if (out_en) begin
			word_q <= {word_q[23:0], octet};
			slot_q <= slot_q + 2'd1;
		end
	end
	assign LINK.lane_data = word_q;
	always_ff @(posedge CLK_I) begin
		// flag a word only once four fresh octets sit in it
		if (!NRST_I || !run_q) begin
			lane_valid_q <= 1'b0;
		end else begin
			lane_valid_q <= out_en && slot_q == 2'd3;
		end
	end
	assign LINK.lane_valid = lane_valid_q;
	assign LINK.link_up = run_q;
	assign ILLEGAL_O = !legal;
	assign BAND_MISMATCH_O = pll_band_q != band_need;
	assign PLL_BAND_O = pll_band_q;
endmodule
`default_nettype wire

// ### jtl_rcv.sv
// receiving end: apb command registers, programs the pll band and collects words
`timescale 1ns/1ps
`default_nettype none
`include "jtl_regs.svh"
module jtl_rcv
	import jtl_pkg::*;
(
	input  wire logic        CLK_I,
	input  wire logic        NRST_I,
	jtl_link_if.rcv          LINK,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic [31:0]      PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O
);
	jtl_cmd_state_t st_q;
	logic [31:0] rate_q;
	logic [7:0]  band_q;
	logic [31:0] rx_q;
	logic        go;
	logic        acc;
	logic [7:0]  band_pick;
	assign acc = PSEL_I && PENABLE_I;
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = acc && !(PADDR_I == `JTL_CTRL_OFS || PADDR_I == `JTL_RATE_OFS
		|| PADDR_I == `JTL_STAT_OFS || PADDR_I == `JTL_PLL_OFS);
	assign go = acc && PWRITE_I && PADDR_I == `JTL_CTRL_OFS && PWDATA_I[0];
	always_comb begin
		// band from lane rate in kbps
		if (rate_q[23:0] < `JTL_SLR_B1_KBPS) band_pick = `JTL_PLL_BAND0;
		else if (rate_q[23:0] < `JTL_SLR_B2_KBPS) band_pick = `JTL_PLL_BAND1;
		else if (rate_q[23:0] <= `JTL_SLR_B3_KBPS) band_pick = `JTL_PLL_BAND2;
		else band_pick = `JTL_PLL_BAND3;
	end
	always_ff @(posedge CLK_I) begin
		// 13 gbps gives 0x00, 6.5 gbps 0x10
		if (!NRST_I) begin
			rate_q <= 32'h0000_0000;
			band_q <= `JTL_PLL_BAND2;
		end else if (acc && PWRITE_I && PADDR_I == `JTL_RATE_OFS) begin
			rate_q <= PWDATA_I;
		end else if (go) begin
			band_q <= band_pick;
		end
	end
	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			st_q <= JTL_IDLE;
		end else begin
			case (st_q)
				JTL_IDLE: if (go) st_q <= JTL_WR;
				JTL_WR: st_q <= JTL_WAIT;
				JTL_WAIT: if (LINK.cfg_ack || !LINK.cfg_we) st_q <= JTL_IDLE;
				default: st_q <= JTL_IDLE;
			endcase
		end
	end
	assign LINK.cfg_we = st_q == JTL_WR;
	assign LINK.cfg_addr = `JTL_PLL_BAND_ADDR;
	assign LINK.cfg_wdata = band_q;
	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			rx_q <= 32'h0000_0000;
		end else if (LINK.lane_valid) begin
			rx_q <= LINK.lane_data;
		end
	end
	always_comb begin
		case (PADDR_I)
			`JTL_CTRL_OFS: PRDATA_O = {31'd0, st_q != JTL_IDLE};
			`JTL_RATE_OFS: PRDATA_O = rate_q;
			`JTL_STAT_OFS: PRDATA_O = {31'd0, LINK.link_up};
			`JTL_PLL_OFS: PRDATA_O = {24'd0, band_q};
			default: PRDATA_O = rx_q;
		endcase
	end
endmodule
`default_nettype wire

// ### jtl_asserts.sv
// concurrent checks on the link between the two ends
`timescale 1ns/1ps
`default_nettype none
`include "jtl_regs.svh"
module jtl_asserts (
	input  wire logic        CLK_I,
	input  wire logic        NRST_I,
	input  wire logic        cfg_we,
	input  wire logic [11:0] cfg_addr,
	input  wire logic [7:0]  cfg_wdata,
	input  wire logic        cfg_ack,
	input  wire logic        link_up,
	input  wire logic [31:0] lane_data,
	input  wire logic        lane_valid
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);
	band_addr_a: assert property (cfg_we |-> cfg_addr == `JTL_PLL_BAND_ADDR)
		else $error("band write aimed off the band register");
	band_value_a: assert property (cfg_we |-> cfg_wdata inside {`JTL_PLL_BAND0,
		`JTL_PLL_BAND1, `JTL_PLL_BAND2, `JTL_PLL_BAND3})
		else $error("band write carries an unknown setting");
	ack_follow_a: assert property (cfg_we |-> cfg_ack)
		else $error("band write not acknowledged");
	ack_release_a: assert property (cfg_ack |=> !cfg_we)
		else $error("band write held past its acknowledge");
	we_spacing_a: assert property (cfg_we |=> !cfg_we [*2])
		else $error("band writes too close");
	word_spacing_a: assert property (lane_valid |=> !lane_valid [*3])
		else $error("lane word sooner than four samples");
	word_steady_a: assert property (lane_valid |-> ##[4:100] (lane_valid || !link_up))
		else $error("lane words stopped while link up");
	idle_link_a: assert property (lane_valid |-> link_up || $past(link_up))
		else $error("lane word while link down");
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench: both ends joined, apb on the receiving end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic        pready, pslverr, ill, bmis, hd = 0, ddc = 0, sctl = 0;
	logic [7:0]  pllb, smpl = 8'ha5;
	logic [2:0]  lanes = 1;
	logic [3:0]  conv = 2, smp = 1, res = 8, chip_decimation_ratio = 1;
	logic [4:0]  oct = 2;
	logic [5:0]  frm = 32;
	logic [1:0]  cs = 0;
	logic [23:0] serial_lane_rate = 24'd10000000, fadc = 24'd500000;
	int          err_count = 0, comparisons = 0, cyc = 0;
	jtl_link_if link ();
	jtl_dev jtl_dev_i (.CLK_I(clk), .NRST_I(nrst), .LINK(link), .LANES_I(lanes),
		.CONV_I(conv), .OCTETS_I(oct), .SAMPLES_I(smp), .FRAMES_I(frm), .CTRL_BITS_I(cs),
		.RESOLUTION_I(res), .HD_I(hd), .DDC_I(ddc), .DCM_I(chip_decimation_ratio), .SLR_KBPS_I(serial_lane_rate),
		.FADC_KSPS_I(fadc), .SAMPLE_I(smpl), .SAMPLE_CTRL_I(sctl), .ILLEGAL_O(ill),
		.BAND_MISMATCH_O(bmis), .PLL_BAND_O(pllb));
	jtl_rcv jtl_rcv_i (.CLK_I(clk), .NRST_I(nrst), .LINK(link), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr));
	jtl_asserts jtl_asserts_i (.CLK_I(clk), .NRST_I(nrst), .cfg_we(link.cfg_we),
		.cfg_addr(link.cfg_addr), .cfg_wdata(link.cfg_wdata), .cfg_ack(link.cfg_ack),
		.link_up(link.link_up), .lane_data(link.lane_data), .lane_valid(link.lane_valid));
	always #25 clk = ~clk;
	task automatic wrap_up();
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// generous ceiling: the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; waits on pready, only the bench timeout ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// program a lane rate, wait for the command to finish, check the band
	task automatic t_band(input logic [23:0] rate, input logic [7:0] band);
		logic [31:0] r;
		logic        e;
		serial_lane_rate <= rate;
		apb(1, 12'h008, {8'h00, rate}, r, e);
		apb(1, 12'h000, 32'h1, r, e);
		r = 1;
		while (r[0] !== 1'b0)
			apb(0, 12'h000, 0, r, e);
		apb(0, 12'h014, 0, r, e);
		chk(r, {24'h0, band});
		chk({24'h0, pllb}, {24'h0, band});
		chk({31'h0, bmis}, 0);
	endtask
	// legal base set, then one field or one linked group of fields changed, legality judged
	task automatic t_try(input int v, input logic e);
		{lanes, conv, oct, smp, frm, cs, res, hd, ddc, chip_decimation_ratio} <= {3'd1, 4'd2, 5'd2, 4'd1,
			6'd32, 2'd0, 4'd8, 1'b0, 1'b0, 4'd1};
		@(posedge clk);
		case (v)
			0: frm <= 30;
			1: frm <= 8;
			2: res <= 9;
			3: cs <= 2;
			4: hd <= 1;
			5: chip_decimation_ratio <= 2;
			6: {conv, ddc} <= {4'd1, 1'b1};
			7: lanes <= 2;
			8: {conv, oct, frm} <= {4'd1, 5'd1, 6'd16};
			10: serial_lane_rate <= 24'd1600000;
			default: frm <= 32;
		endcase
		repeat (2) @(posedge clk);
		chk({31'h0, ill}, {31'h0, e});
	endtask
	task automatic t_link();
		logic [31:0] r;
		logic        e;
		t_band(24'd13000000, 8'h00);
		t_band(24'd6500000, 8'h10);
		t_band(24'd10000000, 8'h00);
		while (link.link_up !== 1'b1)
			@(posedge clk);
		apb(0, 12'h010, 0, r, e);
		chk({31'h0, r[0]}, 1);
		@(posedge clk);
		while (link.lane_valid !== 1'b1)
			@(posedge clk);
		chk(link.lane_data, 32'ha5a5a5a5);
		// control bit replaces the lsb once cs is set; wait out the old octets
		cs <= 1;
		repeat (9) @(posedge clk);
		while (link.lane_valid !== 1'b1)
			@(posedge clk);
		chk(link.lane_data, 32'ha4a4a4a4);
	endtask
	logic [23:0] rt[8] = '{24'd1687500, 24'd3374999, 24'd3375000, 24'd6749999,
		24'd6750000, 24'd13500000, 24'd13500001, 24'd16000000};
	logic [7:0]  bd[8] = '{8'h50, 8'h50, 8'h10, 8'h10, 8'h00, 8'h00, 8'h30, 8'h30};
	initial begin
		logic [31:0] r;
		logic        e;
		repeat (6) @(posedge clk);
		nrst <= 1;
		chk({24'h0, pllb}, 0);
		apb(0, 12'h004, 0, r, e);
		chk({31'h0, e}, 1);
		for (int i = 0; i < 8; i++)
			t_band(rt[i], bd[i]);
		t_link();
		t_try(9, 0);
		t_try(0, 1);
		t_try(1, 1);
		t_try(2, 1);
		t_try(3, 1);
		t_try(4, 1);
		t_try(5, 1);
		t_try(6, 0);
		t_try(7, 1);
		t_try(8, 1);
		chk({31'h0, link.link_up}, 0);
		t_try(10, 1);
		chk({30'h0, ill, bmis}, 32'h3);
		wrap_up();
	end
endmodule
`default_nettype wire
